// File: ddr_cmd_pkg.sv
package ddr_cmd_pkg;

    // pin widths
    localparam int ADDR_W  = 13;
    localparam int BANK_W  = 2;
    localparam int BANKS   = 4;
    localparam int LANES   = 9;
    localparam int DQ_W    = 64;
    localparam int ECC_W   = 8;
    localparam int WORD_W  = DQ_W + ECC_W;

    // address bit roles
    localparam int AP_BIT    = 10;
    localparam int COL_HI    = 11;
    localparam int COL_LO_W  = 10;
    localparam int COL_W     = 11;

    // command code {rowStrobeN, colStrobeN, writeEnableN}
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [2:0] CMD_REFRESH   = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_READ      = 3'h5;

    // mode register select on bank address
    localparam logic [1:0] MODE_SEL_BASE = 2'h0;
    localparam logic [1:0] MODE_SEL_EXT  = 2'h1;

    // cas latency field of the base mode register
    localparam int         CL_POS        = 4;
    localparam int         CL_W          = 3;
    localparam logic [2:0] CL_CODE_2     = 3'h2;
    localparam logic [2:0] CL_CODE_3     = 3'h3;
    localparam logic [2:0] CL_CODE_2P5   = 3'h6;
    localparam logic [1:0] CL_CYCLES_2   = 2'h2;
    localparam logic [1:0] CL_CYCLES_3   = 2'h3;

    // power states
    typedef enum logic [1:0] {
        PW_ACTIVE   = 2'b00,
        PW_PRE_PD   = 2'b01,
        PW_ACT_PD   = 2'b10,
        PW_SELF_REF = 2'b11
    } power_e;

    // register map (byte addresses)
    localparam logic [7:0] OFS_CONFIG    = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_MODE_BASE = 8'h08;
    localparam logic [7:0] OFS_MODE_EXT  = 8'h0C;
    localparam logic [7:0] OFS_CMD_COUNT = 8'h10;

    // field positions
    localparam int CFG_COL_WIDE  = 0;
    localparam int ST_POWER_POS  = 0;
    localparam int ST_BANK_POS   = 4;
    localparam int ST_WPEND_POS  = 8;
    localparam int ST_RBUSY_POS  = 9;

    // reset values
    localparam logic [31:0]       CONFIG_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] MODE_RST   = 13'h0000;

    // ahb codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// File: input_register.sv
`timescale 1ns/1ps

module input_register
    import ddr_cmd_pkg::*;
(
    // clock and resets
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              moduleResetN,
    // sample strobes
    input  wire logic              sampleCmd,
    input  wire logic              sampleCke,
    // raw pins
    input  wire logic              rankSelectN,
    input  wire logic [2:0]        cmdIn,
    input  wire logic [BANK_W-1:0] bankIn,
    input  wire logic [ADDR_W-1:0] addrIn,
    input  wire logic              ckeIn,
    // registered copies
    output logic                   rankSelectN_r,
    output logic [2:0]             cmd_r,
    output logic [BANK_W-1:0]      bank_r,
    output logic [ADDR_W-1:0]      addr_r,
    output logic                   cke_r
);

    logic              rankSelectN_nxt;
    logic [2:0]        cmd_nxt;
    logic [BANK_W-1:0] bank_nxt;
    logic [ADDR_W-1:0] addr_nxt;
    logic              cke_nxt;

    // cke has its own strobe: its buffer stays on in every low-power state
    always_comb
    begin
        rankSelectN_nxt = sampleCmd ? rankSelectN : rankSelectN_r;
        cmd_nxt         = sampleCmd ? cmdIn : cmd_r;
        bank_nxt        = sampleCmd ? bankIn : bank_r;
        addr_nxt        = sampleCmd ? addrIn : addr_r;
        cke_nxt         = sampleCke ? ckeIn : cke_r;
    end

    always_ff @(posedge sys_clk or posedge sys_rst or negedge moduleResetN)
    begin
        if (sys_rst || !moduleResetN)
        begin
            rankSelectN_r <= 1'b0;
            cmd_r         <= 3'h0;
            bank_r        <= '0;
            addr_r        <= '0;
            cke_r         <= 1'b0;
        end
        else
        begin
            rankSelectN_r <= rankSelectN_nxt;
            cmd_r         <= cmd_nxt;
            bank_r        <= bank_nxt;
            addr_r        <= addr_nxt;
            cke_r         <= cke_nxt;
        end
    end

endmodule // input_register

// File: ddr_module_cmd_port.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module ddr_module_cmd_port
    import ddr_cmd_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // module control pins
    input  wire logic               moduleResetN,
    input  wire logic               moduleClockTrue,
    input  wire logic               moduleClockComp,
    input  wire logic               moduleClockEnable,
    input  wire logic               rankSelectN,
    input  wire logic               rowStrobeN,
    input  wire logic               colStrobeN,
    input  wire logic               writeEnableN,
    input  wire logic [BANK_W-1:0]  bankAddr,
    input  wire logic [ADDR_W-1:0]  addrIn,
    input  wire logic [LANES-1:0]   writeMaskLanes,
    // data, check and strobe lanes
    input  wire logic [DQ_W-1:0]    dataIn,
    output logic      [DQ_W-1:0]    dataOut,
    output logic                    dataOe,
    input  wire logic [ECC_W-1:0]   eccCheckLanesIn,
    output logic      [ECC_W-1:0]   eccCheckLanesOut,
    output logic                    eccCheckLanesOe,
    input  wire logic [LANES-1:0]   dataStrobeLanesIn,
    output logic      [LANES-1:0]   dataStrobeLanesOut,
    output logic      [LANES-1:0]   dataStrobeLanesOe,
    // power status
    output logic                    internalClockEn,
    output logic                    inputBufEn,
    output logic                    clockBufEn,
    // ahb-lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic               hready,
    input  wire logic [31:0]        hwdata,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp
);

    localparam int IDX_W = $clog2(DEPTH);

    // crossing detection and input register
    logic                truePrev_r, compPrev_r, crossing;
    logic                rankSelectNReg, ckeReg;
    logic [2:0]          cmdReg;
    logic [BANK_W-1:0]   bankReg;
    logic [ADDR_W-1:0]   addrReg;
    logic                crossSeen_r, crossSeen_nxt, ckePrev_r, ckePrev_nxt;
    power_e              power_r, power_nxt;

    assign crossing = moduleClockTrue && !truePrev_r && !moduleClockComp && compPrev_r;

    input_register u_inreg (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .moduleResetN  (moduleResetN),
        .sampleCmd     (crossing && inputBufEn),
        .sampleCke     (crossing),
        .rankSelectN   (rankSelectN),
        .cmdIn         ({rowStrobeN, colStrobeN, writeEnableN}),
        .bankIn        (bankAddr),
        .addrIn        (addrIn),
        .ckeIn         (moduleClockEnable),
        .rankSelectN_r (rankSelectNReg),
        .cmd_r         (cmdReg),
        .bank_r        (bankReg),
        .addr_r        (addrReg),
        .cke_r         (ckeReg)
    );

    // one decode per crossing: the register's values are valid the cycle after the crossing
    logic cmdValid, isAct, isRead, isWrite, isPre, isLoad, isRefresh;
    assign cmdValid  = crossSeen_r && ckeReg && ckePrev_r && !rankSelectNReg;
    assign isAct     = cmdValid && cmdReg == CMD_ACTIVATE;
    assign isRead    = cmdValid && cmdReg == CMD_READ;
    assign isWrite   = cmdValid && cmdReg == CMD_WRITE;
    assign isPre     = cmdValid && cmdReg == CMD_PRECHARGE;
    assign isLoad    = cmdValid && cmdReg == CMD_LOAD_MODE;
    assign isRefresh = crossSeen_r && ckePrev_r && !rankSelectNReg && cmdReg == CMD_REFRESH;

    logic [BANKS-1:0] bankOpen_r, bankOpen_nxt;
    logic             clkEn_nxt, inBufEn_nxt, clkBufEn_nxt;

    always_comb
    begin
        crossSeen_nxt = crossing;
        ckePrev_nxt   = crossSeen_r ? ckeReg : ckePrev_r;
        power_nxt     = power_r;
        unique case (power_r)
            PW_ACTIVE:
                if (crossSeen_r && !ckeReg && ckePrev_r)
                begin
                    if (bankOpen_r != '0)
                        power_nxt = PW_ACT_PD;
                    else if (isRefresh)
                        power_nxt = PW_SELF_REF;
                    else
                        power_nxt = PW_PRE_PD;
                end
            PW_PRE_PD, PW_ACT_PD:
                if (crossSeen_r && ckeReg)
                    power_nxt = PW_ACTIVE;
            PW_SELF_REF:
                if (moduleClockEnable)
                    power_nxt = PW_ACTIVE;
        endcase
        // internal clock stops at the synchronous power-down entry, as the input buffers do
        clkEn_nxt    = power_nxt == PW_ACTIVE;
        inBufEn_nxt  = power_nxt == PW_ACTIVE;
        clkBufEn_nxt = power_nxt != PW_SELF_REF;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            truePrev_r      <= 1'b1;
            compPrev_r      <= 1'b0;
            crossSeen_r     <= 1'b0;
            ckePrev_r       <= 1'b0;
            power_r         <= PW_PRE_PD;
            internalClockEn <= 1'b0;
            inputBufEn      <= 1'b0;
            clockBufEn      <= 1'b1;
        end
        else
        begin
            truePrev_r      <= moduleClockTrue;
            compPrev_r      <= moduleClockComp;
            crossSeen_r     <= crossSeen_nxt;
            ckePrev_r       <= ckePrev_nxt;
            power_r         <= power_nxt;
            internalClockEn <= clkEn_nxt;
            inputBufEn      <= inBufEn_nxt;
            clockBufEn      <= clkBufEn_nxt;
        end
    end

    // bank state and mode registers
    logic [ADDR_W-1:0] modeBase_r, modeBase_nxt, modeExt_r, modeExt_nxt;
    logic [31:0]       config_r, config_nxt;
    logic [COL_W-1:0]  column;
    logic [IDX_W-1:0]  accessIdx;
    logic              apDone;

    // narrow columns leave the upper column bit zero
    assign column    = {config_r[CFG_COL_WIDE] & addrReg[COL_HI], addrReg[COL_LO_W-1:0]};
    assign accessIdx = IDX_W'({bankReg, column[COL_W-1], column[0]});

    genvar b;
    generate
        for (b = 0; b < BANKS; b++)
        begin : g_bank
            always_comb
            begin
                bankOpen_nxt[b] = bankOpen_r[b];
                if (isAct && bankReg == BANK_W'(b))
                    bankOpen_nxt[b] = 1'b1;
                if (isPre && (addrReg[AP_BIT] || bankReg == BANK_W'(b)))
                    bankOpen_nxt[b] = 1'b0;
                if (apDone && bankReg == BANK_W'(b))
                    bankOpen_nxt[b] = 1'b0;
            end
        end
    endgenerate

    assign apDone = (isRead || isWrite) && addrReg[AP_BIT];

    always_comb
    begin
        modeBase_nxt = modeBase_r;
        modeExt_nxt  = modeExt_r;
        if (isLoad && bankReg == MODE_SEL_BASE)
            modeBase_nxt = addrReg;
        if (isLoad && bankReg == MODE_SEL_EXT)
            modeExt_nxt = addrReg;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bankOpen_r <= '0;
            modeBase_r <= MODE_RST;
            modeExt_r  <= MODE_RST;
        end
        else
        begin
            bankOpen_r <= bankOpen_nxt;
            modeBase_r <= modeBase_nxt;
            modeExt_r  <= modeExt_nxt;
        end
    end

    // data store, write capture and read return
    logic [WORD_W-1:0] mem_r [DEPTH], mem_nxt [DEPTH];
    logic [WORD_W-1:0] wordIn, wordMerged;
    logic [IDX_W-1:0]  wrIdx_r, wrIdx_nxt, rdIdx_r, rdIdx_nxt;
    logic              wrPend_r, wrPend_nxt, strobePrev_r, strobeRise;
    logic [1:0]        rdCnt_r, rdCnt_nxt, rdStage_r, rdStage_nxt, clCycles;
    logic [DQ_W-1:0]   dOut_nxt;
    logic [ECC_W-1:0]  eOut_nxt;
    logic              oe_nxt, strobe_nxt;
    logic [31:0]       cmdCount_r, cmdCount_nxt;

    assign wordIn     = {eccCheckLanesIn, dataIn};
    assign strobeRise = dataStrobeLanesIn[0] && !strobePrev_r;

    // 2.5 has no half-cycle here, so it rounds up to three crossings
    assign clCycles = modeBase_r[CL_POS +: CL_W] == CL_CODE_2 ? CL_CYCLES_2 : CL_CYCLES_3;

    genvar l;
    generate
        for (l = 0; l < LANES; l++)
        begin : g_lane
            assign wordMerged[l*8 +: 8] = writeMaskLanes[l] ? mem_r[wrIdx_r][l*8 +: 8]
                                                            : wordIn[l*8 +: 8];
        end
    endgenerate

    always_comb
    begin
        mem_nxt    = mem_r;
        wrIdx_nxt  = wrIdx_r;
        wrPend_nxt = wrPend_r;
        rdIdx_nxt  = rdIdx_r;
        rdCnt_nxt  = rdCnt_r;
        rdStage_nxt = rdStage_r;
        dOut_nxt   = dataOut;
        eOut_nxt   = eccCheckLanesOut;
        oe_nxt     = dataOe;
        strobe_nxt = dataStrobeLanesOut[0];
        cmdCount_nxt = cmdCount_r + 32'(cmdValid);
        if (wrPend_r && strobeRise)
        begin
            mem_nxt[wrIdx_r] = wordMerged;
            wrPend_nxt = 1'b0;
        end
        if (isWrite)
        begin
            wrIdx_nxt  = accessIdx;
            wrPend_nxt = 1'b1;
        end
        if (isRead)
        begin
            rdIdx_nxt = accessIdx;
            rdCnt_nxt = clCycles;
        end
        else if (crossing && rdCnt_r != 2'h0)
        begin
            rdCnt_nxt = rdCnt_r - 2'h1;
            if (rdCnt_r == 2'h1)
                rdStage_nxt = 2'h1;
        end
        if (crossing)
        begin
            unique case (rdStage_r)
                2'h1:
                begin
                    {eOut_nxt, dOut_nxt} = mem_r[rdIdx_r];
                    oe_nxt      = 1'b1;
                    strobe_nxt  = 1'b1;
                    rdStage_nxt = 2'h2;
                end
                2'h2:
                begin
                    strobe_nxt  = 1'b0;
                    rdStage_nxt = 2'h3;
                end
                2'h3:
                begin
                    oe_nxt      = 1'b0;
                    rdStage_nxt = 2'h0;
                end
                default:
                    ;
            endcase
        end
        if (!moduleClockEnable)
            oe_nxt = 1'b0;
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_r[i] <= '0;
            wrIdx_r            <= '0;
            wrPend_r           <= 1'b0;
            rdIdx_r            <= '0;
            rdCnt_r            <= 2'h0;
            rdStage_r          <= 2'h0;
            strobePrev_r       <= 1'b0;
            dataOut            <= '0;
            eccCheckLanesOut   <= '0;
            dataOe             <= 1'b0;
            eccCheckLanesOe    <= 1'b0;
            dataStrobeLanesOut <= '0;
            dataStrobeLanesOe  <= '0;
            cmdCount_r         <= '0;
        end
        else
        begin
            mem_r              <= mem_nxt;
            wrIdx_r            <= wrIdx_nxt;
            wrPend_r           <= wrPend_nxt;
            rdIdx_r            <= rdIdx_nxt;
            rdCnt_r            <= rdCnt_nxt;
            rdStage_r          <= rdStage_nxt;
            strobePrev_r       <= dataStrobeLanesIn[0];
            dataOut            <= dOut_nxt;
            eccCheckLanesOut   <= eOut_nxt;
            dataOe             <= oe_nxt;
            eccCheckLanesOe    <= oe_nxt;
            dataStrobeLanesOut <= {LANES{strobe_nxt}};
            dataStrobeLanesOe  <= {LANES{oe_nxt}};
            cmdCount_r         <= cmdCount_nxt;
        end
    end

    // ahb-lite slave: zero wait states, read data registered in the address phase
    logic        wrPhase_r, wrPhase_nxt;
    logic [7:0]  wrAddr_r, wrAddr_nxt;
    logic [31:0] rdata_nxt, status;
    logic        take;

    assign take   = hsel && hready && htrans == HTRANS_NONSEQ;
    assign status = 32'({power_r == PW_ACTIVE ? 1'b0 : 1'b1, rdStage_r != 2'h0, wrPend_r,
                         bankOpen_r, 2'h0, power_r});

    always_comb
    begin
        wrPhase_nxt = take && hwrite;
        wrAddr_nxt  = take ? haddr[7:0] : wrAddr_r;
        config_nxt  = config_r;
        rdata_nxt   = hrdata;
        if (wrPhase_r && wrAddr_r == OFS_CONFIG)
            config_nxt = {31'h0, hwdata[CFG_COL_WIDE]};
        if (take && !hwrite)
        begin
            unique case (haddr[7:0])
                OFS_CONFIG:    rdata_nxt = config_r;
                OFS_STATUS:    rdata_nxt = status;
                OFS_MODE_BASE: rdata_nxt = 32'(modeBase_r);
                OFS_MODE_EXT:  rdata_nxt = 32'(modeExt_r);
                OFS_CMD_COUNT: rdata_nxt = cmdCount_r;
                default:       rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPhase_r <= 1'b0;
            wrAddr_r  <= 8'h00;
            config_r  <= CONFIG_RST;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
        else
        begin
            wrPhase_r <= wrPhase_nxt;
            wrAddr_r  <= wrAddr_nxt;
            config_r  <= config_nxt;
            hrdata    <= rdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

endmodule // ddr_module_cmd_port

// File: host_clock_model.sv
`timescale 1ns/1ps
module host_clock_model
(
    // system side
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // module clock pair
    output logic      moduleClockTrue,
    output logic      moduleClockComp
);
    logic half_r;
    // pair flips every second cycle, so crossings come four cycles apart
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            half_r          <= 1'h0;
            moduleClockTrue <= 1'h0;
            moduleClockComp <= 1'h1;
        end
        else
        begin
            half_r <= ~half_r;
            if (half_r)
            begin
                moduleClockTrue <= ~moduleClockTrue;
                moduleClockComp <= moduleClockTrue;
            end
        end
    end
endmodule // host_clock_model

// File: ddr_cmd_port_monitor.sv
`timescale 1ns/1ps
module ddr_cmd_port_monitor
    import ddr_cmd_pkg::*;
(
    // clock and reset
    input wire logic             sys_clk,
    input wire logic             sys_rst,
    // watched pins and status
    input wire logic             moduleClockEnable,
    input wire logic             dataOe,
    input wire logic             eccCheckLanesOe,
    input wire logic [LANES-1:0] dataStrobeLanesOut,
    input wire logic [LANES-1:0] dataStrobeLanesOe,
    input wire logic             internalClockEn,
    input wire logic             inputBufEn,
    input wire logic             clockBufEn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // four cycles per crossing only holds with the bench's host model
    sequence strobeHigh; dataStrobeLanesOut[0] [*4]; endsequence
    sequence strobeLow; (dataOe && !dataStrobeLanesOut[0]) [*4] ##1 !dataOe; endsequence
    chk_read_shape: assert property ($rose(dataOe) |-> strobeHigh ##1 strobeLow)
        else $error("read strobe shape");
    chk_lane_equal: assert property (dataStrobeLanesOut == {LANES{dataStrobeLanesOut[0]}})
        else $error("strobe lanes differ");
    chk_lane_enable: assert property
        (dataStrobeLanesOe == {LANES{dataOe}} && eccCheckLanesOe == dataOe)
        else $error("lane enables differ");
    chk_cke_off: assert property (!moduleClockEnable |=> !dataOe)
        else $error("outputs on after enable low");
    chk_sref_exit: assert property (!clockBufEn && moduleClockEnable |=> clockBufEn)
        else $error("self refresh exit late");
    chk_sref_bufs: assert property (!clockBufEn |-> !inputBufEn)
        else $error("buffers on in self refresh");
    chk_active_run: assert property (inputBufEn |-> internalClockEn && clockBufEn)
        else $error("clock off while active");
    chk_oe_active: assert property (dataOe |-> inputBufEn && $past(moduleClockEnable))
        else $error("drive outside active");
endmodule // ddr_cmd_port_monitor

bind ddr_module_cmd_port ddr_cmd_port_monitor i_mon (.sys_clk, .sys_rst, .moduleClockEnable,
    .dataOe, .eccCheckLanesOe, .dataStrobeLanesOut, .dataStrobeLanesOe, .internalClockEn,
    .inputBufEn, .clockBufEn);

// File: registered_ddr_module_cmd_port_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin errTotal++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module registered_ddr_module_cmd_port_test
    import ddr_cmd_pkg::*;
;
    logic sys_clk, sys_rst, moduleResetN, moduleClockEnable, rankSelectN, dataOe;
    logic moduleClockTrue, moduleClockComp, rowStrobeN, colStrobeN, writeEnableN;
    logic eccCheckLanesOe, internalClockEn, inputBufEn, clockBufEn, hwrite, hreadyout, hresp;
    logic [BANK_W-1:0] bankAddr;
    logic [ADDR_W-1:0] addrIn;
    logic [LANES-1:0]  writeMaskLanes, dataStrobeLanesIn, dataStrobeLanesOut, dataStrobeLanesOe;
    logic [DQ_W-1:0]   dataIn, dataOut;
    logic [ECC_W-1:0]  eccCheckLanesIn, eccCheckLanesOut;
    logic [31:0]       haddr, hwdata, hrdata, q;
    logic [1:0]        htrans;
    int                errTotal, testsRun, cyc, n;
    logic [72:0]       rows [5] = '{{1'h0, OFS_MODE_BASE, 32'h0, 32'h0},
        {1'h0, OFS_CMD_COUNT, 32'h0, 32'h0}, {1'h1, OFS_CONFIG, 32'h1, 32'h1},
        {1'h1, OFS_CONFIG, 32'h0, 32'h0}, {1'h1, 8'h20, 32'hFFFF_FFFF, 32'h0}};

    host_clock_model i_host (.sys_clk, .sys_rst, .moduleClockTrue, .moduleClockComp);
    ddr_module_cmd_port #(.DEPTH(16)) i_dut (.sys_clk, .sys_rst, .moduleResetN, .moduleClockTrue,
        .moduleClockComp, .moduleClockEnable, .rankSelectN, .rowStrobeN, .colStrobeN,
        .writeEnableN, .bankAddr, .addrIn, .writeMaskLanes, .dataIn, .dataOut, .dataOe,
        .eccCheckLanesIn, .eccCheckLanesOut, .eccCheckLanesOe, .dataStrobeLanesIn,
        .dataStrobeLanesOut, .dataStrobeLanesOe, .internalClockEn, .inputBufEn, .clockBufEn,
        .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
        .hrdata, .hreadyout, .hresp);

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            errTotal++;
            wrapUp();
        end
    end

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    // pins held from one falling true edge to the next, around one crossing
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
        input logic k);
        @(negedge moduleClockTrue);
        {rowStrobeN, colStrobeN, writeEnableN} <= c;
        bankAddr <= b;
        addrIn <= a;
        moduleClockEnable <= k;
        @(negedge moduleClockTrue);
        {rowStrobeN, colStrobeN, writeEnableN} <= 3'h7;
        addrIn <= ~a;
        @(posedge moduleClockTrue);
    endtask
    task automatic wr(input logic [71:0] v, input logic [8:0] m);
        cmd(CMD_WRITE, 2'h1, 13'h0001, 1'h1);
        @(negedge moduleClockTrue);
        {eccCheckLanesIn, dataIn} <= v;
        writeMaskLanes <= m;
        dataStrobeLanesIn <= 9'h1FF;
        @(negedge moduleClockTrue);
        dataStrobeLanesIn <= 9'h000;
        {eccCheckLanesIn, dataIn} <= ~v;
    endtask
    task automatic rd(input logic [12:0] a, input logic [71:0] v);
        cmd(CMD_READ, 2'h1, a, 1'h1);
        n = 0;
        do begin @(posedge moduleClockTrue); n++; end while (dataOe !== 1'h1 && n < 8);
        `CHK("latency", 4'(CL_CYCLES_2) + 4'h1, 4'(n))
        `CHK("read word", v, {eccCheckLanesOut, dataOut})
    endtask
    task automatic lowp(input logic [2:0] c, input logic [1:0] p);
        cmd(c, 2'h0, 13'h0000, 1'h0);
        repeat (2) @(posedge moduleClockTrue);
        ahb(1'h0, OFS_STATUS, 32'h0);
        `CHK("power", p, q[1:0])
        `CHK("low power flag", 1'h1, q[10])
        `CHK("internal clock off", 1'h0, internalClockEn)
        `CHK("input buffers", 1'h0, inputBufEn)
        `CHK("clock buffers", p != 2'h3, clockBufEn)
        moduleClockEnable <= 1'h1;
        repeat (3) @(posedge moduleClockTrue);
        `CHK("power exit", 1'h1, inputBufEn)
    endtask

    initial
    begin
        {sys_rst, rowStrobeN, colStrobeN, writeEnableN} = 4'hF;
        {moduleResetN, moduleClockEnable, rankSelectN, bankAddr, addrIn, writeMaskLanes} = '0;
        {dataIn, eccCheckLanesIn, dataStrobeLanesIn, haddr, htrans, hwrite, hwdata} = '0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'h0;
        moduleClockEnable <= 1'h1;
        for (int i = 0; i < 5; i++)
        begin
            if (rows[i][72])
                ahb(1'h1, rows[i][71:64], rows[i][63:32]);
            ahb(1'h0, rows[i][71:64], 32'h0);
            `CHK("register", rows[i][31:0], q)
            `CHK("response", HRESP_OKAY, hresp)
        end
        $display("register rows done");
        // module reset still low: registered enable stays cleared
        `CHK("held input buffers", 1'h0, inputBufEn)
        `CHK("held data drive", 1'h0, dataOe)
        moduleResetN <= 1'h1;
        repeat (3) @(posedge moduleClockTrue);
        `CHK("input buffers on", 1'h1, inputBufEn)
        `CHK("internal clock on", 1'h1, internalClockEn)
        cmd(CMD_LOAD_MODE, MODE_SEL_BASE, 13'(CL_CODE_2) << CL_POS, 1'h1);
        ahb(1'h0, OFS_MODE_BASE, 32'h0);
        `CHK("mode base", 32'(CL_CODE_2) << CL_POS, q)
        cmd(CMD_ACTIVATE, 2'h1, 13'h0123, 1'h1);
        cmd(CMD_ACTIVATE, 2'h3, 13'h0042, 1'h1);
        wr({9{8'hAA}}, 9'h000);
        wr({9{8'h55}}, 9'h002);
        writeMaskLanes <= 9'h1FF;
        rd(13'h0001, {{7{8'h55}}, 8'hAA, 8'h55});
        rankSelectN <= 1'h1;
        cmd(CMD_READ, 2'h1, 13'h0001, 1'h1);
        repeat (3) @(posedge moduleClockTrue);
        `CHK("deselected read", 1'h0, dataOe)
        rankSelectN <= 1'h0;
        rd(13'h0401, {{7{8'h55}}, 8'hAA, 8'h55});
        ahb(1'h0, OFS_STATUS, 32'h0);
        `CHK("open banks", 4'h8, q[7:4])
        cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 1'h1);
        ahb(1'h0, OFS_STATUS, 32'h0);
        `CHK("open banks", 4'h0, q[7:4])
        $display("command path done");
        lowp(3'h7, 2'h1);
        lowp(CMD_REFRESH, 2'h3);
        cmd(CMD_ACTIVATE, 2'h0, 13'h0007, 1'h1);
        lowp(3'h7, 2'h2);
        $display("power states done");
        wrapUp();
    end
endmodule // registered_ddr_module_cmd_port_test
